// file: include/fpe_defines.vh
/*
 * constants for the flash program/erase/protect block: register offsets,
 * control field positions, reset values and array geometry.
 * assumes it is included by bare name from the design files.
 */
`ifndef FPE_DEFINES_VH
`define FPE_DEFINES_VH

// register byte offsets on the axi4-lite slave
`define FPE_OFS_CTRL      8'h00
`define FPE_OFS_PROT      8'h04
`define FPE_OFS_ADDR      8'h08
`define FPE_OFS_DATA      8'h0C
`define FPE_OFS_STAT      8'h10

// flash_control field positions
`define FPE_BIT_PGM       0
`define FPE_BIT_ERASE     1
`define FPE_BIT_MASS      2
`define FPE_BIT_HIGH_VOLTAGE_ENABLE      3

// reset values
`define FPE_CTRL_RST      4'h0
`define FPE_PROT_RST      8'hFF
`define FPE_ADDR_RST      16'h0000

// array geometry: 8-kbyte array at the top of the 64-kbyte space
`define FPE_ARRAY_BASE    3'h7
`define FPE_PROT_ADDR     16'hFF7E
`define FPE_ALL_ONES      8'hFF
`define FPE_PAGE_LAST     13'h003F
`define FPE_MASS_LAST     13'h1FFF

// axi response codes
`define FPE_RESP_OKAY     2'h0
`define FPE_RESP_SLVERR   2'h2

`endif

// file: src/fpe_mem.v
/*
 * byte-wide array storage with one write port and a registered read port.
 * assumes the owner serialises writes; read data lag the address by one cycle.
 */
`timescale 1ns/100ps
module fpe_mem #(
  parameter AW = 13,
  parameter DW = 8
) (
  input  wire          i_clk,
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [DW-1:0] i_wdata,
  input  wire [AW-1:0] i_raddr,
  output reg  [DW-1:0] o_rdata
);

  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port and registered read port
  always @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule

// file: src/fpe_prot.v
/*
 * protect decoder: forms the protect start address from the boundary byte
 * and flags an address that lies in the protected range.
 * assumes the test voltage input is already synchronised.
 */
`timescale 1ns/100ps
`include "fpe_defines.vh"
module fpe_prot (
  input  wire [7:0]  i_boundary,
  input  wire [15:0] i_addr,
  input  wire        i_test_hv,
  output wire        o_protected
);

  wire [15:0] start_addr;
  wire        open_all;
  wire        in_range;
  wire        locks_self;

  // boundary bits become address bits 13..6, top two ones, low six zeros
  assign start_addr  = {2'b11, i_boundary, 6'b000000};             // [RL21]
  // all ones leaves the array open; lowest codes fall at or below the base
  assign open_all    = (i_boundary == `FPE_ALL_ONES);              // [RL20]
  assign in_range    = ~open_all & (i_addr >= start_addr);         // [RL20] [RL21]
  // a programmed boundary byte locks itself unless test voltage is present
  assign locks_self  = ~open_all & (i_addr == `FPE_PROT_ADDR);     // [RL22]
  assign o_protected = ~i_test_hv & (in_range | locks_self);       // [RL22]

endmodule

// file: src/fpe_top.v
/*
 * flash program/erase/protect sequencer with an axi4-lite register slave.
 * holds flash_control, the protect_boundary shadow, an array address and
 * data window, and a status word; drives the array storage and the
 * erase engine. assumes one clock, synchronous active-high reset, and a
 * test-voltage detect level arriving asynchronously from a pin.
 */
// Implementation choices: the register offsets and the AXI4-Lite register port.
// How it works
// RL1: hv enable sets only with one select active after read and dummy write.
// RL2: mass bit with erase select erases the whole 8-kbyte array.
// RL3: a write setting erase and program together leaves both unchanged.
// RL4: page erase: erase select, read boundary, write inside target page.
// RL5: software waits at least 10 us after dummy write before hv enable.
// RL6: page erase keeps high voltage at least 1 ms or 4 ms.
// RL7: use 4 ms page erase beyond 1000 cycles; 1 ms for speed.
// RL8: after clearing erase select, wait 5 us before clearing hv enable.
// RL9: mass erase: both selects, read boundary, write any address, hold 4 ms.
// RL10: after ending mass erase, wait 100 us before clearing hv enable.
// RL11: mass erase is refused unless the boundary is all ones.
// RL12: after hv enable clears, allow about 1 us before reading the array.
// RL13: programming works within one 32-byte aligned row.
// RL14: software programs only bytes that currently read all ones.
// RL15: program: select, read boundary, dummy write, hv on, wait 5 us.
// RL16: write each byte, wait 30 us each, then drop select, hold, drop hv.
// RL17: gaps between programmed bytes must not exceed max programming time.
// RL18: software reads the boundary after select and before hv enable.
// RL19: hv enable is blocked when the latched address is protected.
// RL20: boundary all zeros or lowest code protects all; all ones protects none.
// RL21: start address is 11, boundary bits, six zeros; protect to the top.
// RL22: a programmed boundary locks itself and its range except under test voltage.
// RL23: program and erase code must run from memory outside the array.
`timescale 1ns/100ps
`include "fpe_defines.vh"
module fpe_top #(
  parameter AW = 13
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_test_hv,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready
);

  // word-aligned offset match
  function is_ofs;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      is_ofs = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // true when a 16-bit address falls inside the array
  function in_array;
    input [15:0] addr;
    begin
      in_array = (addr[15:13] == `FPE_ARRAY_BASE);
    end
  endfunction

  reg  [2:0]    hv_sync_q;
  reg           test_hv_q;
  reg           aw_full_q;
  reg  [7:0]    aw_addr_q;
  reg           w_full_q;
  reg  [31:0]   w_data_q;
  reg  [3:0]    w_strb_q;
  reg           pgm_q;
  reg           erase_q;
  reg           mass_q;
  reg           high_voltage_enable_q;
  reg  [7:0]    boundary_q;
  reg  [15:0]   addr_q;
  reg           seq_read_q;
  reg           seq_latched_q;
  reg  [15:0]   latch_addr_q;
  reg           hv_refused_q;
  reg           erasing_q;
  reg  [AW-1:0] er_cnt_q;
  reg  [AW-1:0] er_last_q;
  reg  [AW-1:0] er_base_q;
  reg  [31:0]   rdata_d;
  reg  [1:0]    rresp_d;

  wire          do_wr;
  wire          do_rd;
  wire          wr_ctrl;
  wire          wr_addr;
  wire          wr_data;
  wire          rd_prot;
  wire          sel_any;
  wire          want_pgm;
  wire          want_erase;
  wire          both_sel;
  wire          new_pgm;
  wire          new_erase;
  wire          hv_req;
  wire          hv_ok;
  wire          latch_prot;
  wire          cur_prot;
  wire          prog_wr;
  wire          er_hit_bnd;
  wire          mem_we;
  wire [AW-1:0] mem_waddr;
  wire [7:0]    mem_wdata;
  wire [7:0]    mem_rd;
  wire [AW-1:0] er_addr;

  // three-stage pin synchroniser; level moves once stages two and three agree
  always @(posedge i_clk) begin
    if (i_srst) begin
      hv_sync_q <= 3'h0;
      test_hv_q <= 1'b0;
    end else begin
      hv_sync_q <= {hv_sync_q[1:0], i_test_hv};
      if (hv_sync_q[1] == hv_sync_q[2]) begin
        test_hv_q <= hv_sync_q[2];
      end
    end
  end

  // axi write address and data captured independently, answered together
  assign o_awready = ~aw_full_q & ~o_bvalid;
  assign o_wready  = ~w_full_q & ~o_bvalid;
  assign do_wr     = aw_full_q & w_full_q & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  assign do_rd     = i_arvalid & o_arready;

  always @(posedge i_clk) begin
    if (i_srst) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `FPE_RESP_OKAY;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (wr_ctrl | wr_addr | wr_data | is_ofs(aw_addr_q, `FPE_OFS_PROT) |
                      is_ofs(aw_addr_q, `FPE_OFS_STAT)) ? `FPE_RESP_OKAY : `FPE_RESP_SLVERR;
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // write decode; control and data use byte lane zero
  assign wr_ctrl = do_wr & is_ofs(aw_addr_q, `FPE_OFS_CTRL);
  assign wr_addr = do_wr & is_ofs(aw_addr_q, `FPE_OFS_ADDR);
  assign wr_data = do_wr & is_ofs(aw_addr_q, `FPE_OFS_DATA) & w_strb_q[0];
  assign rd_prot = do_rd & is_ofs(i_araddr, `FPE_OFS_PROT);

  // select interlock: a request for both keeps the present pair
  assign want_pgm   = w_data_q[`FPE_BIT_PGM];
  assign want_erase = w_data_q[`FPE_BIT_ERASE];
  assign both_sel   = want_pgm & want_erase;                         // [RL3]
  assign new_pgm    = both_sel ? pgm_q : want_pgm;                   // [RL3]
  assign new_erase  = both_sel ? erase_q : want_erase;               // [RL3]
  assign sel_any    = pgm_q | erase_q;

  // hv enable gate: one select, boundary read, dummy write, no protection
  assign hv_req = wr_ctrl & w_strb_q[0] & w_data_q[`FPE_BIT_HIGH_VOLTAGE_ENABLE] & ~high_voltage_enable_q;
  assign hv_ok  = (pgm_q ^ erase_q) & (new_pgm == pgm_q) & (new_erase == erase_q) &
                  seq_read_q & seq_latched_q & ~latch_prot &         // [RL1] [RL19]
                  ~(erase_q & mass_q & (boundary_q != `FPE_ALL_ONES)) & // [RL11]
                  ~(erase_q & ~test_hv_q & (boundary_q != `FPE_ALL_ONES) &    // [RL22]
                    ((latch_addr_q | {3'h0, `FPE_PAGE_LAST}) ==
                     (`FPE_PROT_ADDR | {3'h0, `FPE_PAGE_LAST}))); // page holding the boundary

  // protection of the latched target and of the current window address
  fpe_prot u_prot_latch (
    .i_boundary  (boundary_q),
    .i_addr      (latch_addr_q),
    .i_test_hv   (test_hv_q),
    .o_protected (latch_prot)
  );

  fpe_prot u_prot_cur (
    .i_boundary  (boundary_q),
    .i_addr      (addr_q),
    .i_test_hv   (test_hv_q),
    .o_protected (cur_prot)
  );

  // control register, sequence tracking and refusal flag
  always @(posedge i_clk) begin
    if (i_srst) begin
      {high_voltage_enable_q, mass_q, erase_q, pgm_q} <= `FPE_CTRL_RST;
      seq_read_q    <= 1'b0;
      seq_latched_q <= 1'b0;
      latch_addr_q  <= `FPE_ADDR_RST;
      hv_refused_q  <= 1'b0;
      addr_q        <= `FPE_ADDR_RST;
    end else begin
      if (wr_ctrl & w_strb_q[0]) begin
        pgm_q        <= new_pgm;
        erase_q      <= new_erase;
        mass_q       <= w_data_q[`FPE_BIT_MASS];
        hv_refused_q <= hv_req & ~hv_ok;
        if (~w_data_q[`FPE_BIT_HIGH_VOLTAGE_ENABLE]) begin
          high_voltage_enable_q <= 1'b0;
        end else if (hv_req & hv_ok) begin
          high_voltage_enable_q <= 1'b1;                                            // [RL1]
        end
        // a change of selection restarts the sequence
        if ((new_pgm != pgm_q) | (new_erase != erase_q)) begin
          seq_read_q    <= 1'b0;
          seq_latched_q <= 1'b0;
        end
      end else begin
        // boundary read after select arms the sequence
        if (rd_prot & sel_any & ~high_voltage_enable_q) begin
          seq_read_q <= 1'b1;
        end
        // dummy write after the read latches the target address
        if (wr_data & sel_any & seq_read_q & ~high_voltage_enable_q & ~seq_latched_q &
            in_array(addr_q)) begin
          seq_latched_q <= 1'b1;
          latch_addr_q  <= addr_q;
        end
      end
      if (wr_addr) begin
        if (w_strb_q[0]) addr_q[7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) addr_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // a programming write lands only in the latched row while hv is on
  assign prog_wr = wr_data & pgm_q & high_voltage_enable_q & seq_latched_q & in_array(addr_q) &
                   ~cur_prot &
                   (addr_q[15:5] == latch_addr_q[15:5]);             // [RL13]

  // erase engine walks the page or the whole array once hv comes on
  assign er_addr    = er_base_q + er_cnt_q;
  assign er_hit_bnd = ({`FPE_ARRAY_BASE, er_addr} == `FPE_PROT_ADDR);

  always @(posedge i_clk) begin
    if (i_srst) begin
      erasing_q <= 1'b0;
      er_cnt_q  <= {AW{1'b0}};
      er_last_q <= {AW{1'b0}};
      er_base_q <= {AW{1'b0}};
    end else if (erasing_q) begin
      er_cnt_q <= er_cnt_q + 1'b1;
      if ((er_cnt_q == er_last_q) | ~high_voltage_enable_q) begin
        erasing_q <= 1'b0;
      end
    end else if (hv_req & hv_ok & erase_q) begin
      erasing_q <= 1'b1;
      er_cnt_q  <= {AW{1'b0}};
      if (mass_q) begin
        er_base_q <= {AW{1'b0}};                                     // [RL2]
        er_last_q <= `FPE_MASS_LAST;                                 // [RL2]
      end else begin
        er_base_q <= {latch_addr_q[AW-1:6], 6'b000000};
        er_last_q <= `FPE_PAGE_LAST;
      end
    end
  end

  // boundary shadow follows erase and programming of its own byte
  always @(posedge i_clk) begin
    if (i_srst) begin
      boundary_q <= `FPE_PROT_RST;
    end else if (erasing_q & er_hit_bnd) begin
      boundary_q <= `FPE_ALL_ONES;
    end else if (prog_wr & (addr_q == `FPE_PROT_ADDR)) begin
      boundary_q <= boundary_q & w_data_q[7:0];                      // [RL22]
    end
  end

  // array write port: erase fills ones, programming only clears bits
  assign mem_we    = erasing_q | prog_wr;
  assign mem_waddr = erasing_q ? er_addr : addr_q[AW-1:0];
  assign mem_wdata = erasing_q ? `FPE_ALL_ONES : (mem_rd & w_data_q[7:0]);

  fpe_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (addr_q[AW-1:0]),
    .o_rdata (mem_rd)
  );

  // read multiplexer
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `FPE_RESP_OKAY;
    if (is_ofs(i_araddr, `FPE_OFS_CTRL)) begin
      rdata_d[3:0] = {high_voltage_enable_q, mass_q, erase_q, pgm_q};
    end else if (is_ofs(i_araddr, `FPE_OFS_PROT)) begin
      rdata_d[7:0] = boundary_q;
    end else if (is_ofs(i_araddr, `FPE_OFS_ADDR)) begin
      rdata_d[15:0] = addr_q;
    end else if (is_ofs(i_araddr, `FPE_OFS_DATA)) begin
      rdata_d[7:0] = in_array(addr_q) ? mem_rd : `FPE_ALL_ONES;
    end else if (is_ofs(i_araddr, `FPE_OFS_STAT)) begin
      rdata_d[4:0] = {test_hv_q, hv_refused_q, seq_latched_q, seq_read_q, erasing_q};
    end else begin
      rresp_d = `FPE_RESP_SLVERR;
    end
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= `FPE_RESP_OKAY;
    end else if (do_rd) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rdata_d;
      o_rresp  <= rresp_d;
    end else if (o_rvalid & i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

endmodule

// file: bench/fpe_top_chk.sv
/* port checker for fpe_top: axi handshake timing, read answers and
   control readback. assumes it is bound onto fpe_top, one clock, sync reset. */
`timescale 1ns/100ps
`include "fpe_defines.vh"
module fpe_top_chk (
  input wire        i_clk,
  input wire        i_srst,
  input wire        i_awvalid,
  input wire        o_awready,
  input wire        i_wvalid,
  input wire        o_wready,
  input wire [1:0]  o_bresp,
  input wire        o_bvalid,
  input wire        i_bready,
  input wire [7:0]  i_araddr,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0]  o_rresp,
  input wire        o_rvalid,
  input wire        i_rready
);
  reg [7:0] ra_q;
  // address of the read in flight
  always @(posedge i_clk) begin
    if (i_arvalid && o_arready) ra_q <= i_araddr;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // answers hold until taken, and new requests wait for them
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answer pending");
  a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |->
    ##[1:2] o_bvalid) else $error("write not answered in time");
  a_unmapped_read: assert property (i_arvalid && o_arready && i_araddr > 8'h13 |=>
    o_rresp == `FPE_RESP_SLVERR && o_rdata == 32'h0) else $error("unmapped read not refused");
  a_sel_interlock: assert property (o_rvalid && ra_q == `FPE_OFS_CTRL |->
    o_rdata[31:4] == 28'h0 && !(o_rdata[0] && o_rdata[1])) else $error("both selects set");
  a_reset_idle: assert property ($past(i_srst) |-> !o_bvalid && !o_rvalid)
    else $error("answer pending after reset");
  c_write: cover property (o_bvalid && i_bready);
  c_read: cover property (o_rvalid && i_rready);
  c_slverr: cover property (o_rvalid && o_rresp == `FPE_RESP_SLVERR);
endmodule
bind fpe_top fpe_top_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_rready(i_rready));

// file: bench/fpe_top_tb.sv
/* self-checking bench for fpe_top with an array and boundary model.
   assumes the register map and answer timing of fpe_top. */
`timescale 1ns/100ps
`include "fpe_defines.vh"
module fpe_top_tb;
  reg         i_clk = 0, i_srst = 1, i_test_hv = 0;
  reg  [7:0]  i_awaddr = 0, i_araddr = 0;
  reg         i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  reg  [31:0] i_wdata = 0;
  wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire [1:0]  o_bresp, o_rresp;
  wire [31:0] o_rdata;
  integer     fails = 0, total_checks = 0, i, j;
  reg  [7:0]  mm [0:8191];
  reg  [7:0]  bnd = 8'hFF;
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [15:0] lat, ta [0:5];
  reg  [3:0]  ts [0:5];
  reg         ok, lng;
  // free-running clock
  always #50 i_clk = ~i_clk;
  fpe_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_test_hv(i_test_hv),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // axi write: address, data and bready together; response taken at the bvalid edge
  task wr(input [7:0] ad, input [31:0] dt);
    @(posedge i_clk);
    i_awaddr <= ad; i_awvalid <= 1; i_wdata <= dt; i_wvalid <= 1; i_bready <= 1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (!o_bvalid);
    chk(o_bresp, `FPE_RESP_OKAY);
    i_bready <= 0;
  endtask
  task rd(input [7:0] ad);
    @(posedge i_clk);
    i_araddr <= ad; i_arvalid <= 1; i_rready <= 1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 0;
    end while (!o_rvalid);
    d = o_rdata; r = o_rresp;
    i_rready <= 0;
  endtask
  task rdc(input [7:0] ad, input [31:0] e);
    rd(ad); chk(d, e); chk(r, `FPE_RESP_OKAY);
  endtask
  function pm(input [15:0] x);
    pm = !i_test_hv && bnd != 8'hFF && (x == `FPE_PROT_ADDR || x >= {2'b11, bnd, 6'h0});
  endfunction
  // select, read boundary, dummy write, then ask for high voltage; runs outside the array
  task try(input [3:0] sel, input [15:0] x);
    wr(`FPE_OFS_CTRL, sel); rd(`FPE_OFS_PROT); wr(`FPE_OFS_ADDR, x);
    wr(`FPE_OFS_DATA, $urandom); lat = x;
    repeat (100) @(posedge i_clk);
    wr(`FPE_OFS_CTRL, sel | 4'h8);
    ok = sel[2] ? bnd == 8'hFF : !pm(x) && !(sel[1] && pm(`FPE_PROT_ADDR) &&
      (x | 16'h3F) == (`FPE_PROT_ADDR | 16'h3F));
    lng = ok && sel[2];
    rdc(`FPE_OFS_CTRL, ok ? sel | 4'h8 : sel);
    if (ok && sel[0]) repeat (50) @(posedge i_clk);
    if (ok && sel[1]) begin
      repeat (sel[2] ? 40000 : 10000) @(posedge i_clk);
      rdc(`FPE_OFS_STAT, {27'h0, i_test_hv, 4'h6});
      for (j = 0; j < 8192; j = j + 1) if (sel[2] || j[12:6] == x[12:6]) mm[j] = 8'hFF;
      if (sel[2] || (x | 16'h3F) == (`FPE_PROT_ADDR | 16'h3F)) bnd = 8'hFF;
    end
  endtask
  // drop selects under high voltage, hold, drop high voltage, let reads recover
  task fin;
    wr(`FPE_OFS_CTRL, 4'h8);
    repeat (lng ? 1000 : 50) @(posedge i_clk);
    wr(`FPE_OFS_CTRL, 0);
    repeat (10) @(posedge i_clk);
  endtask
  task program_select(input [15:0] x, input [7:0] v);
    wr(`FPE_OFS_ADDR, x); wr(`FPE_OFS_DATA, v);
    repeat (300) @(posedge i_clk);
    if (x[15:5] == lat[15:5] && !pm(x)) begin
      mm[x[12:0]] = mm[x[12:0]] & v;
      if (x == `FPE_PROT_ADDR) bnd = bnd & v;
    end
  endtask
  task cmp(input [15:0] x);
    wr(`FPE_OFS_ADDR, x); rdc(`FPE_OFS_DATA, {24'h0, mm[x[12:0]]});
  endtask
  // main sequence
  initial begin
    ta[0] = 16'hFF7F; ta[1] = 16'hFF80; ta[2] = 16'hFFFF; ta[3] = 16'hFF80; ta[4] = 16'hE000;
    ta[5] = 16'hFF40;
    ts[0] = 4'h1; ts[1] = 4'h1; ts[2] = 4'h1; ts[3] = 4'h2; ts[4] = 4'h6; ts[5] = 4'h2;
    d = $urandom(32'h16A90F30);
    repeat (6) @(posedge i_clk);
    i_srst <= 0;
    rdc(`FPE_OFS_CTRL, 0); rdc(`FPE_OFS_PROT, 32'hFF); rdc(`FPE_OFS_STAT, 0);
    rd(8'h14); chk(d, 0); chk(r, `FPE_RESP_SLVERR);
    wr(`FPE_OFS_CTRL, 3); rdc(`FPE_OFS_CTRL, 0);
    wr(`FPE_OFS_CTRL, 2); wr(`FPE_OFS_CTRL, 4'hA); rdc(`FPE_OFS_CTRL, 2);
    rdc(`FPE_OFS_STAT, 8);
    try(6, 16'hE123); fin;
    try(1, 16'hE020);
    for (i = 0; i < 34; i = i + 1) program_select(16'hE01F + i, $urandom);
    fin;
    for (i = 0; i < 34; i = i + 1) cmp(16'hE01F + i);
    try(2, 16'hE005); fin;
    for (i = 0; i < 34; i = i + 1) cmp(16'hE01F + i);
    try(1, 16'hFF60); program_select(`FPE_PROT_ADDR, 8'hFE); fin;
    rdc(`FPE_OFS_PROT, 32'hFE);
    for (i = 0; i < 6; i = i + 1) begin
      try(ts[i], ta[i]); fin;
    end
    i_test_hv <= 1;
    repeat (8) @(posedge i_clk);
    rd(`FPE_OFS_STAT); chk(d & 32'h10, 32'h10);
    try(1, 16'hFF80); program_select(16'hFF80, $urandom); fin; cmp(16'hFF80);
    try(2, 16'hFF60); fin; rdc(`FPE_OFS_PROT, 32'hFF);
    try(1, 16'hFF60); program_select(`FPE_PROT_ADDR, 8'h00); fin; rdc(`FPE_OFS_PROT, 32'h0);
    i_test_hv <= 0;
    repeat (8) @(posedge i_clk);
    try(1, 16'hE000); fin;
    end_of_test;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge i_clk);
    fails = fails + 1;
    end_of_test;
  end
endmodule
